//--- logic/atc_pkg.sv
// package: task-file layout, opcodes, status bits and sense codes for the command block
// assumes: 16-bit data words, 256 words per sector
package atc_pkg;
	localparam logic [7:0] OP_NATIVE_MAX   = 8'hf8;
	localparam logic [7:0] OP_READ_SECTORS = 8'h20;
	localparam logic [7:0] OP_VERIFY_A     = 8'h40;
	localparam logic [7:0] OP_VERIFY_B     = 8'h41;
	localparam logic [7:0] OP_SENSE        = 8'h03;
	localparam logic [7:0] OP_DISABLE_PW   = 8'hf6;
	localparam int         DH_LBA_BIT      = 6;
	localparam int         DH_DEV_BIT      = 4;
	localparam int         WORDS_PER_SECT  = 256;
	localparam int         PW_FIRST_WORD   = 1;
	localparam int         PW_LAST_WORD    = 16;
	localparam int         PW_ID_BIT       = 0;
	localparam logic [7:0] SENSE_NONE      = 8'h00;
	localparam logic [7:0] SENSE_SELFTEST  = 8'h01;
	localparam logic [7:0] SENSE_WRITE     = 8'h03;
	localparam logic [7:0] SENSE_MISC      = 8'h09;
	localparam logic [7:0] SENSE_IDNF      = 8'h10;
	localparam logic [7:0] SENSE_UNCORR    = 8'h11;
	localparam logic [7:0] SENSE_CORR      = 8'h18;
	localparam logic [7:0] SENSE_ABORT     = 8'h1f;
	localparam logic [7:0] SENSE_BADADDR   = 8'h21;
	localparam logic [7:0] SENSE_OVERFLOW  = 8'h2f;
	localparam logic [7:0] SENSE_SPARE     = 8'h3a;
	localparam logic [7:0] SENSE_VOLTAGE   = 8'h35;
	localparam logic [7:0] SENSE_DIAG      = 8'h05;
	localparam logic [7:0] SENSE_MEDIA     = 8'h0c;
	localparam logic [27:0] NATIVE_MAX_DEF = 28'h0ffffff;
	localparam logic       DEV_NUMBER_DEF  = 1'b0;
	// host register map
	localparam logic [3:0] HA_CMD   = 4'h0;
	localparam logic [3:0] HA_LBA   = 4'h1;
	localparam logic [3:0] HA_COUNT = 4'h2;
	localparam logic [3:0] HA_DATA  = 4'h3;
	localparam logic [3:0] HA_STAT  = 4'h4;
	localparam logic [3:0] HA_RES   = 4'h5;
	localparam logic [3:0] HA_FEAT  = 4'h6;
	localparam int         HS_BUSY  = 0;
	localparam int         HS_ERR   = 1;
	localparam int         HS_PWOK  = 2;
	localparam int         HS_VALID = 3;
	localparam int         HS_DONE  = 4;
endpackage : atc_pkg

//--- logic/atc_if.sv
// interface: task-file link between host controller and drive command block
// assumes: one clock shared by both ends
`timescale 1ns/10ps
interface atc_if;
	logic        cmd_valid;
	logic [7:0]  command_opcode;
	logic [7:0]  drive_head_select;
	logic [7:0]  address_high_byte;
	logic [7:0]  address_mid_byte;
	logic [7:0]  address_low_byte;
	logic [7:0]  transfer_length;
	logic [7:0]  command_parameter;
	logic        busy;
	logic        data_request;
	logic        irq;
	logic        error;
	logic [7:0]  error_code;
	logic [7:0]  res_drive_head;
	logic [7:0]  res_high;
	logic [7:0]  res_mid;
	logic [7:0]  res_low;
	logic [7:0]  res_count;
	logic        rd_strobe;
	logic        wr_strobe;
	logic [15:0] rd_word;
	logic [15:0] wr_word;
	modport dev (input cmd_valid, command_opcode, drive_head_select, address_high_byte,
		address_mid_byte, address_low_byte, transfer_length, command_parameter,
		rd_strobe, wr_strobe, wr_word,
		output busy, data_request, irq, error, error_code, res_drive_head, res_high,
		res_mid, res_low, res_count, rd_word);
	modport host (output cmd_valid, command_opcode, drive_head_select, address_high_byte,
		address_mid_byte, address_low_byte, transfer_length, command_parameter,
		rd_strobe, wr_strobe, wr_word,
		input busy, data_request, irq, error, error_code, res_drive_head, res_high,
		res_mid, res_low, res_count, rd_word);
endinterface : atc_if

//--- logic/atc_drive.sv
// drive end: executes native-max, sector read, verify, sense and password disable
// assumes: a media model on the user side answers each sector fetch in later cycles
// Summary of operation
// - native max opcode returns address as LBA
// - host sets LBA bit for native max
// - host device bit names target drive
// - read 1..256 sectors, zero means 256
// - start at addressed sector
// - per sector: busy, load, request, interrupt
// - host reads 512 bytes per request
// - read error stops, reports failing address
// - verify like read, no data request
// - verify busy then one final interrupt
// - verify error reports address and remainder
// - sense opcode puts extended code in error
// - codes 21h, 2Fh, 09h
// - codes 1Fh, 03h, 3Ah
// - codes 01h; 05h,30h-34h,37h,3Eh
// - codes 35h/36h, 11h, 18h, 10h/14h
// - password disable takes one host sector
// - unlock only if selected password matches
// - master password kept on disable
// - payload: word0 bit0 id, words 1-16 password
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/10ps
module atc_drive
	import atc_pkg::*;
#(
	parameter logic [27:0] NATIVE_MAX = NATIVE_MAX_DEF,
	parameter logic        DEV_NUMBER = DEV_NUMBER_DEF
) (
	input  wire logic         clock,
	input  wire logic         reset_n,
	atc_if.dev                link,
	output logic              media_req,
	output logic [27:0]       media_lba,
	input  wire logic         media_ack,
	input  wire logic         media_fail,
	input  wire logic [7:0]   media_code,
	input  wire logic [15:0]  media_word,
	output logic [7:0]        media_idx,
	input  wire logic [255:0] user_password,
	input  wire logic [255:0] master_password,
	input  wire logic         locked_in,
	output logic              unlock
);
	typedef enum logic [2:0] {S_IDLE, S_FETCH, S_XFER, S_PWIN, S_DONE} atc_state_type;
	atc_state_type state_r;
	logic [27:0]  lba_r;
	logic [8:0]   left_r;
	logic [7:0]   widx_r;
	logic         verify_r;
	logic [7:0]   last_code_r;
	logic         pw_sel_r;
	logic         pw_eq_r;
	logic [15:0]  buf_r [WORDS_PER_SECT];
	logic         req_r;
	logic         unlock_r;

	function automatic logic [8:0] count_of(input logic [7:0] c);
		count_of = (c == 8'h00) ? 9'h100 : {1'b0, c};
	endfunction : count_of

	function automatic logic [15:0] pw_word(input logic [255:0] p, input logic [7:0] i);
		pw_word = p[(i - 8'h01) * 16 +: 16];
	endfunction : pw_word

	wire         cmd_take = link.cmd_valid && state_r == S_IDLE
		&& link.drive_head_select[DH_DEV_BIT] == DEV_NUMBER;
	wire         is_verify = link.command_opcode == OP_VERIFY_A
		|| link.command_opcode == OP_VERIFY_B;
	wire [27:0]  cmd_lba = {link.drive_head_select[3:0], link.address_high_byte,
		link.address_mid_byte, link.address_low_byte};
	wire [15:0]  pw_ref = pw_word(pw_sel_r ? master_password : user_password, widx_r);
	wire         pw_word_ok = link.wr_word == pw_ref;
	wire         in_pw = widx_r >= 8'(PW_FIRST_WORD) && widx_r <= 8'(PW_LAST_WORD);

	assign media_req = req_r;
	assign media_lba = lba_r;
	assign media_idx = widx_r;
	assign unlock    = unlock_r;
	assign link.rd_word = buf_r[widx_r];

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= S_IDLE;
			lba_r <= 28'h0;
			left_r <= 9'h0;
			widx_r <= 8'h0;
			verify_r <= 1'b0;
			last_code_r <= SENSE_NONE;
			pw_sel_r <= 1'b0;
			pw_eq_r <= 1'b0;
			req_r <= 1'b0;
			unlock_r <= 1'b0;
			link.busy <= 1'b0;
			link.data_request <= 1'b0;
			link.irq <= 1'b0;
			link.error <= 1'b0;
			link.error_code <= SENSE_NONE;
			link.res_drive_head <= 8'h0;
			link.res_high <= 8'h0;
			link.res_mid <= 8'h0;
			link.res_low <= 8'h0;
			link.res_count <= 8'h0;
		end else begin
			link.irq <= 1'b0;
			unlock_r <= 1'b0;
			unique case (state_r)
				S_IDLE: if (cmd_take) begin
					link.error <= 1'b0;
					lba_r <= cmd_lba;
					left_r <= count_of(link.transfer_length);
					verify_r <= is_verify;
					widx_r <= 8'h0;
					if (link.command_opcode == OP_NATIVE_MAX) begin
						link.res_drive_head <= {link.drive_head_select[7:4], NATIVE_MAX[27:24]};
						link.res_high <= NATIVE_MAX[23:16];
						link.res_mid <= NATIVE_MAX[15:8];
						link.res_low <= NATIVE_MAX[7:0];
						last_code_r <= SENSE_NONE;
						link.irq <= 1'b1;
					end else if (link.command_opcode == OP_SENSE) begin
						link.error_code <= last_code_r;
						link.irq <= 1'b1;
					end else if (link.command_opcode == OP_READ_SECTORS || is_verify) begin
						link.busy <= 1'b1;
						req_r <= 1'b1;
						state_r <= S_FETCH;
					end else if (link.command_opcode == OP_DISABLE_PW) begin
						link.busy <= 1'b0;
						link.data_request <= 1'b1;
						pw_eq_r <= 1'b1;
						state_r <= S_PWIN;
					end else begin
						link.error <= 1'b1;
						last_code_r <= SENSE_ABORT;
						link.irq <= 1'b1;
					end
				end
				S_FETCH: begin
					if (media_ack) begin
						buf_r[widx_r] <= media_word;
						widx_r <= widx_r + 8'h1;
					end
					if (media_ack && widx_r == 8'hff) begin
						req_r <= 1'b0;
						widx_r <= 8'h0;
						link.res_drive_head <= {4'h0, lba_r[27:24]};
						link.res_high <= lba_r[23:16];
						link.res_mid <= lba_r[15:8];
						link.res_low <= lba_r[7:0];
						link.res_count <= left_r[7:0];
						last_code_r <= media_fail ? media_code : SENSE_NONE;
						if (media_fail) begin
							link.error <= 1'b1;
							link.busy <= 1'b0;
							link.irq <= 1'b1;
							link.data_request <= !verify_r;
							state_r <= verify_r ? S_IDLE : S_XFER;
							left_r <= 9'h1;
						end else if (verify_r) begin
							if (left_r == 9'h1) begin
								link.busy <= 1'b0;
								link.irq <= 1'b1;
								link.res_count <= 8'h0;
								state_r <= S_IDLE;
							end else begin
								left_r <= left_r - 9'h1;
								lba_r <= lba_r + 28'h1;
								req_r <= 1'b1;
							end
						end else begin
							link.busy <= 1'b0;
							link.data_request <= 1'b1;
							link.irq <= 1'b1;
							state_r <= S_XFER;
						end
					end
				end
				S_XFER: if (link.rd_strobe) begin
					widx_r <= widx_r + 8'h1;
					if (widx_r == 8'hff) begin
						link.data_request <= 1'b0;
						if (left_r == 9'h1) begin
							state_r <= S_IDLE;
						end else begin
							left_r <= left_r - 9'h1;
							lba_r <= lba_r + 28'h1;
							link.busy <= 1'b1;
							req_r <= 1'b1;
							state_r <= S_FETCH;
						end
					end
				end
				S_PWIN: if (link.wr_strobe) begin
					widx_r <= widx_r + 8'h1;
					if (widx_r == 8'h0) begin
						pw_sel_r <= link.wr_word[PW_ID_BIT];
					end else if (in_pw && !pw_word_ok) begin
						pw_eq_r <= 1'b0;
					end
					if (widx_r == 8'hff) begin
						link.data_request <= 1'b0;
						link.busy <= 1'b1;
						state_r <= S_DONE;
					end
				end
				S_DONE: begin
					link.busy <= 1'b0;
					link.irq <= 1'b1;
					unlock_r <= pw_eq_r && locked_in;
					link.error <= !pw_eq_r;
					last_code_r <= pw_eq_r ? SENSE_NONE : SENSE_ABORT;
					state_r <= S_IDLE;
				end
			endcase
		end
	end
endmodule : atc_drive

//--- logic/atc_host.sv
// host end: register-driven controller issuing one command and moving sector words
// assumes: software port with read data one cycle after the read strobe
`timescale 1ns/10ps
module atc_host
	import atc_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        reset_n,
	atc_if.host              link,
	input  wire logic [3:0]  sw_addr,
	input  wire logic [31:0] sw_wdata,
	input  wire logic        sw_write,
	input  wire logic        sw_read,
	output logic [31:0]      sw_rdata
);
	logic [31:0] rdata_r;
	logic [15:0] word_r;
	logic        done_r;
	logic        irq_seen_r;
	logic        go_r;

	wire [31:0] rmux = (sw_addr == HA_DATA)  ? {16'h0, link.rd_word} :
		(sw_addr == HA_STAT) ? {27'h0, done_r, link.data_request, 1'b0, link.error,
			link.busy} :
		(sw_addr == HA_RES)  ? {link.res_drive_head, link.res_high, link.res_mid,
			link.res_low} :
		(sw_addr == HA_COUNT) ? {16'h0, link.error_code, link.res_count} : 32'h0;

	assign sw_rdata = rdata_r;
	assign link.cmd_valid = go_r;
	assign link.wr_word = word_r;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= 32'h0;
			word_r <= 16'h0;
			done_r <= 1'b0;
			irq_seen_r <= 1'b0;
			go_r <= 1'b0;
			link.command_opcode <= 8'h0;
			link.drive_head_select <= 8'h0;
			link.address_high_byte <= 8'h0;
			link.address_mid_byte <= 8'h0;
			link.address_low_byte <= 8'h0;
			link.transfer_length <= 8'h0;
			link.command_parameter <= 8'h0;
			link.rd_strobe <= 1'b0;
			link.wr_strobe <= 1'b0;
		end else begin
			go_r <= 1'b0;
			link.rd_strobe <= 1'b0;
			link.wr_strobe <= 1'b0;
			rdata_r <= sw_read ? rmux : 32'h0;
			if (sw_write) begin
				unique case (sw_addr)
					HA_CMD: begin
						link.command_opcode <= sw_wdata[7:0];
						done_r <= 1'b0;
						go_r <= 1'b1;
					end
					HA_LBA: begin
						link.drive_head_select <= sw_wdata[31:24] | 8'h40;
						link.address_high_byte <= sw_wdata[23:16];
						link.address_mid_byte <= sw_wdata[15:8];
						link.address_low_byte <= sw_wdata[7:0];
					end
					HA_COUNT: link.transfer_length <= sw_wdata[7:0];
					HA_FEAT: link.command_parameter <= sw_wdata[7:0];
					HA_DATA: if (link.data_request) begin
						word_r <= sw_wdata[15:0];
						link.wr_strobe <= 1'b1;
					end
					default: ;
				endcase
			end
			if (link.irq)
				done_r <= 1'b1;
			if (sw_read && sw_addr == HA_DATA && link.data_request)
				link.rd_strobe <= 1'b1;
		end
	end
endmodule : atc_host

//--- verification/atc_link_properties.sv
// checker: timing relations on the link between host end and drive end
// assumes: one clock, reset_n asynchronous active low, drive answers to device number 0
`timescale 1ns/10ps
module atc_link_properties
	import atc_pkg::*;
#(
	parameter logic [27:0] NATIVE_MAX = NATIVE_MAX_DEF
) (
	input wire logic       clock,
	input wire logic       reset_n,
	input wire logic       cmd_valid,
	input wire logic [7:0] command_opcode,
	input wire logic [7:0] drive_head_select,
	input wire logic       busy,
	input wire logic       data_request,
	input wire logic       irq,
	input wire logic       error,
	input wire logic [7:0] res_drive_head,
	input wire logic [7:0] res_high,
	input wire logic [7:0] res_mid,
	input wire logic [7:0] res_low,
	input wire logic       rd_strobe,
	input wire logic       wr_strobe
);
	logic [7:0] op_r;
	logic [8:0] words_r;
	wire        own_dev = drive_head_select[DH_DEV_BIT] == DEV_NUMBER_DEF;
	wire        take    = cmd_valid && !busy && !data_request && own_dev;
	wire        verify  = command_opcode == OP_VERIFY_A || command_opcode == OP_VERIFY_B;
	wire        known   = command_opcode inside {OP_NATIVE_MAX, OP_READ_SECTORS, OP_VERIFY_A,
		OP_VERIFY_B, OP_SENSE, OP_DISABLE_PW};
	wire        op_ver  = op_r == OP_VERIFY_A || op_r == OP_VERIFY_B;
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			op_r    <= 8'h00;
			words_r <= 9'h000;
		end else begin
			op_r    <= take ? command_opcode : op_r;
			words_r <= data_request ? words_r + {8'h00, rd_strobe | wr_strobe} : 9'h000;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	sequence s_take_verify;
		take && verify;
	endsequence
	sequence s_take_max;
		take && command_opcode == OP_NATIVE_MAX;
	endsequence
	a_dreq_not_busy: assert property (data_request |-> !busy)
		else $error("data request raised while busy");
	a_read_dreq_irq: assert property ($rose(data_request) && op_r == OP_READ_SECTORS |-> irq)
		else $error("sector offered without interrupt");
	a_verify_sets_busy: assert property (s_take_verify |=> busy)
		else $error("verify accepted without busy");
	a_verify_no_dreq: assert property (op_ver |-> !data_request)
		else $error("data request during verify");
	a_native_max: assert property (s_take_max |=> irq && res_drive_head[3:0] == NATIVE_MAX[27:24]
		&& res_high == NATIVE_MAX[23:16] && res_mid == NATIVE_MAX[15:8]
		&& res_low == NATIVE_MAX[7:0])
		else $error("native maximum address wrong or late");
	a_irq_one_cycle: assert property (irq |=> !irq)
		else $error("interrupt longer than one cycle");
	a_sector_words: assert property ($fell(data_request) |-> words_r == 9'h100)
		else $error("data request ended after wrong word count");
	a_refuse_unknown: assert property (take && !known |=> irq && error)
		else $error("unknown opcode not refused");
	a_other_device: assert property (cmd_valid && !busy && !own_dev |=> !busy && !irq)
		else $error("command for other device accepted");
endmodule : atc_link_properties

//--- verification/tb_top.sv
// testbench: host and drive ends on one link; software port and media side driven here
// assumes: media answers one word per clock once a fetch is seen
`timescale 1ns/10ps
module tb_top
	import atc_pkg::*;
;
	localparam logic [27:0] MAX_LBA = 28'h5a3c1e7;
	logic         clock, reset_n, sw_write, sw_read, media_req, media_ack, media_fail;
	logic         locked_in, unlock;
	logic [3:0]   sw_addr;
	logic [31:0]  sw_wdata, sw_rdata, rd;
	logic [7:0]   media_code, media_idx;
	logic [15:0]  media_word;
	logic [27:0]  media_lba, fail_lba, served;
	logic [255:0] user_pw, master_pw;
	int           fails, samples_checked, irqs, unlocks;
	atc_if link ();
	atc_drive #(.NATIVE_MAX(MAX_LBA)) atc_drive_inst (.clock(clock), .reset_n(reset_n),
		.link(link.dev), .media_req(media_req), .media_lba(media_lba), .media_ack(media_ack),
		.media_fail(media_fail), .media_code(media_code), .media_word(media_word),
		.media_idx(media_idx), .user_password(user_pw), .master_password(master_pw),
		.locked_in(locked_in), .unlock(unlock));
	atc_host atc_host_inst (.clock(clock), .reset_n(reset_n), .link(link.host),
		.sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
		.sw_rdata(sw_rdata));
	atc_link_properties #(.NATIVE_MAX(MAX_LBA)) atc_link_properties_inst (.clock(clock),
		.reset_n(reset_n), .cmd_valid(link.cmd_valid), .command_opcode(link.command_opcode),
		.drive_head_select(link.drive_head_select), .busy(link.busy),
		.data_request(link.data_request), .irq(link.irq), .error(link.error),
		.res_drive_head(link.res_drive_head), .res_high(link.res_high), .res_mid(link.res_mid),
		.res_low(link.res_low), .rd_strobe(link.rd_strobe), .wr_strobe(link.wr_strobe));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	always @(posedge clock) begin
		if (link.irq === 1'b1) irqs++;
		if (unlock === 1'b1) unlocks++;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
		samples_checked++;
		if (seen !== want) begin
			fails++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, want);
		end
	endtask : check
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : stop_test
	task automatic sw_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		sw_addr  <= a;
		sw_wdata <= d;
		sw_write <= 1'b1;
		@(posedge clock);
		sw_write <= 1'b0;
	endtask : sw_wr
	task automatic sw_rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clock);
		sw_addr <= a;
		sw_read <= 1'b1;
		@(posedge clock);
		sw_read <= 1'b0;
		#1 d = sw_rdata;
	endtask : sw_rd
	task automatic issue(input logic [7:0] op, input logic [31:0] lba, input logic [7:0] cnt);
		sw_wr(HA_LBA, lba);
		sw_wr(HA_COUNT, {24'h000000, cnt});
		sw_wr(HA_CMD, {24'h000000, op});
	endtask : issue
	task automatic run(input logic [7:0] op, input logic [31:0] lba, input logic [7:0] cnt);
		int n;
		n = irqs + 1;
		issue(op, lba, cnt);
		for (int k = 0; k < 3000 && irqs < n; k++) @(negedge clock);
		check(32'(irqs >= n), 32'h1, "interrupt");
	endtask : run
	// media side: 256 words per fetch, failure flagged on the last word of fail_lba
	initial begin
		media_ack  = 1'b0;
		media_fail = 1'b0;
		media_word = 16'h0000;
		forever begin
			@(posedge clock);
			if (media_req === 1'b1) begin
				served = media_lba;
				for (int i = 0; i < 256; i++) begin
					media_ack  <= 1'b1;
					media_word <= {served[7:0], 8'(i)};
					media_fail <= i == 255 && served == fail_lba;
					@(posedge clock);
				end
				media_ack  <= 1'b0;
				media_fail <= 1'b0;
				while (media_req === 1'b1 && media_lba == served) @(posedge clock);
			end
		end
	end
	task automatic s_native;
		run(OP_NATIVE_MAX, 32'h0, 8'h00);
		check(32'(link.drive_head_select[DH_LBA_BIT]), 32'h1, "lba mode");
		check({4'h0, link.res_drive_head[3:0], link.res_high, link.res_mid, link.res_low},
			{4'h0, MAX_LBA}, "native max");
		sw_rd(HA_STAT, rd);
		check(rd, 32'h00000010, "status after native max");
		sw_rd(HA_RES, rd);
		check(rd, {4'h4, MAX_LBA}, "result register");
	endtask : s_native
	task automatic s_read;
		fail_lba = 28'h0abcd11;
		run(OP_READ_SECTORS, 32'h0abcd10, 8'h03);
		for (int s = 0; s < 2; s++) begin
			if (s == 1) run(OP_SENSE, 32'h0, 8'h00);
			if (s == 1) check(32'(link.res_low), 32'h11, "failing address");
			for (int i = 0; i < 256; i++) begin
				sw_rd(HA_DATA, rd);
				check(32'(rd[15:0]), {16'h0, 8'h10 + 8'(s), 8'(i)}, "sector word");
			end
		end
		repeat (400) @(negedge clock);
		check(32'(media_lba == 28'h0abcd12), 32'h0, "stopped at flawed sector");
	endtask : s_read
	task automatic s_verify;
		fail_lba = 28'h0000302;
		run(OP_VERIFY_B, 32'h0000300, 8'h00);
		check(32'(link.res_count), 32'd254, "sectors left");
		check(32'(link.res_low), 32'h02, "verify failing address");
		check(32'(link.error), 32'h1, "verify error");
		sw_rd(HA_COUNT, rd);
		check(32'(rd[7:0]), 32'd254, "count register");
	endtask : s_verify
	task automatic s_sense;
		logic [7:0] codes [18] = '{SENSE_NONE, SENSE_SELFTEST, SENSE_WRITE, SENSE_MISC,
			SENSE_IDNF, 8'h14, SENSE_UNCORR, SENSE_CORR, SENSE_BADADDR, SENSE_OVERFLOW,
			SENSE_SPARE, SENSE_VOLTAGE, 8'h36, SENSE_DIAG, 8'h30, 8'h3e, SENSE_MEDIA, 8'h3f};
		foreach (codes[k]) begin
			@(posedge clock);
			media_code <= codes[k];
			fail_lba = codes[k] == SENSE_NONE ? 28'hfffffff : 28'h0000400;
			run(OP_VERIFY_A, 32'h0000400, 8'h01);
			run(OP_SENSE, 32'h0, 8'h00);
			check(32'(link.error_code), 32'(codes[k]), "sense code");
		end
		run(8'h00, 32'h0, 8'h00);
		run(OP_SENSE, 32'h0, 8'h00);
		check(32'(link.error_code), 32'(SENSE_ABORT), "abort code");
	endtask : s_sense
	task automatic s_pw(input logic master, input logic good);
		logic [255:0] pw;
		int n;
		pw = master ? master_pw : user_pw;
		n = unlocks;
		issue(OP_DISABLE_PW, 32'h0, 8'h00);
		for (int k = 0; k < 3000 && link.data_request !== 1'b1; k++) @(negedge clock);
		for (int w = 0; w < WORDS_PER_SECT; w++) begin
			if (w == 0) rd = {31'h0, master};
			else if (w <= PW_LAST_WORD) rd = {16'h0, pw[(w-1)*16 +: 16] ^ {15'h0, !good}};
			else rd = 32'h0;
			sw_wr(HA_DATA, rd);
		end
		repeat (40) @(negedge clock);
		check(32'(unlocks - n), 32'(good), "unlock");
	endtask : s_pw
	initial begin
		#1000000;
		fails++;
		stop_test();
	end
	initial begin
		{sw_write, sw_read, sw_addr, sw_wdata, media_code} = '0;
		{fails, samples_checked, irqs, unlocks} = '0;
		locked_in = 1'b1;
		fail_lba  = 28'hfffffff;
		user_pw   = {16{16'h5ac3}};
		master_pw = {16{16'h1e97}};
		reset_n   = 1'b0;
		repeat (12) @(posedge clock);
		reset_n <= 1'b1;
		s_native();
		s_read();
		s_verify();
		s_sense();
		s_pw(1'b0, 1'b1);
		s_pw(1'b1, 1'b1);
		s_pw(1'b0, 1'b0);
		issue(OP_NATIVE_MAX, 32'h10000000, 8'h00);
		rd = irqs;
		repeat (20) @(negedge clock);
		check(32'(irqs), rd, "other device");
		stop_test();
	end
endmodule : tb_top
